/* File: cebt_defines.svh */
// constants for can error confinement and nominal bit timing
`ifndef CEBT_DEFINES_SVH
`define CEBT_DEFINES_SVH
`define CEBT_IPT_TQ 5'h02
`define CEBT_BIT_TQ_MIN 5'h08
`define CEBT_BIT_TQ_MAX 5'h19
`define CEBT_FLAG_BITS 4'h6
`define CEBT_DELIM_BITS 4'h8
`define CEBT_INTER_BITS 4'h3
`define CEBT_DOM_FIRST 4'he
`define CEBT_DOM_NEXT 4'h8
`define CEBT_WARN_LVL 9'h060
`define CEBT_PASSIVE_LVL 9'h080
`define CEBT_BUSOFF_LVL 9'h100
`define CEBT_REC_MAX 8'hff
`define CEBT_REC_TOP_ACTIVE 8'h7f
`define CEBT_REC_RESTORE 8'h7f
`define CEBT_INC_RX 5'h01
`define CEBT_INC_ERR 5'h08
`define CEBT_RECOV_BITS 4'hb
`define CEBT_RECOV_SEQ 8'h80
`endif

/* File: cebt_pkg.sv */
// types and timing helpers for can error confinement and bit timing
`include "cebt_defines.svh"
package cebt_pkg;
  typedef enum logic [1:0] {cebt_active, cebt_passive, cebt_bus_off} cebt_err_state_t;
  typedef enum logic [2:0] {st_frame, st_flag, st_trail, st_delim, st_inter, st_ovl} cebt_fsm_t;
  // second phase segment: longer of phase one and the processing time
  function automatic logic [4:0] cebt_ph2_len(input logic [2:0] ph1);
    logic [4:0] p;
    p = {2'h0, ph1} + 5'h01;
    return (p > `CEBT_IPT_TQ) ? p : `CEBT_IPT_TQ;
  endfunction
  // whole bit in quanta: sync + prop + phase one + phase two
  function automatic logic [4:0] cebt_bit_len(input logic [2:0] prop, input logic [2:0] ph1);
    return 5'h03 + {2'h0, prop} + {2'h0, ph1} + cebt_ph2_len(ph1);
  endfunction
endpackage

/* File: cebt_if.sv */
// signals between bit timer, error counters and confinement core
`timescale 1ns/10ps
`default_nettype none
interface cebt_if import cebt_pkg::*; ();
  logic bit_start;
  logic sample_pt;
  logic rx_bit;
  logic [4:0] tec_inc;
  logic [4:0] rec_inc;
  logic tec_dec;
  logic rec_dec;
  logic clr;
  logic [8:0] tec;
  logic [7:0] rec;
  cebt_err_state_t state;
  logic warn;
  modport tmr (output bit_start, sample_pt, rx_bit);
  modport cnt (input tec_inc, rec_inc, tec_dec, rec_dec, clr, output tec, rec, state, warn);
  modport core (input bit_start, sample_pt, rx_bit, tec, rec, state, warn,
    output tec_inc, rec_inc, tec_dec, rec_dec, clr);
endinterface
`default_nettype wire

/* File: cebt_bit_timer.sv */
// nominal bit timing: quantum prescaler, segment counter, sample point
`timescale 1ns/10ps
`default_nettype none
`include "cebt_defines.svh"
module cebt_bit_timer import cebt_pkg::*; #(
  parameter int PRESC_W = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // timing setup
  input wire logic [PRESC_W-1:0] presc,
  input wire logic [2:0] prop_seg,
  input wire logic [2:0] ph1_seg,
  // bus level
  input wire logic rx_pin,
  // bit events
  cebt_if.tmr bus
);
  typedef struct packed {
    logic [PRESC_W-1:0] div;
    logic [4:0] tq;
    logic bit_start;
    logic sample_pt;
    logic rx_bit;
  } cebt_tmr_st_t;
  localparam cebt_tmr_st_t TMR_RST = '{div: '0, tq: 5'h00, bit_start: 1'b0,
    sample_pt: 1'b0, rx_bit: 1'b1};
  cebt_tmr_st_t q, d;
  always_comb begin
    d = q;
    d.bit_start = 1'b0;
    d.sample_pt = 1'b0;
    if (q.div == presc) begin
      d.div = '0;
      d.tq = (q.tq == cebt_bit_len(prop_seg, ph1_seg) - 5'h01) ? 5'h00 : q.tq + 5'h01;
      d.bit_start = (d.tq == 5'h00);
      if (q.tq == {2'h0, prop_seg} + {2'h0, ph1_seg} + 5'h02) begin
        d.sample_pt = 1'b1;
        d.rx_bit = rx_pin;
      end
    end else begin
      d.div = q.div + PRESC_W'(1);
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= TMR_RST;
    end else begin
      q <= d;
    end
  end
  assign bus.bit_start = q.bit_start;
  assign bus.sample_pt = q.sample_pt;
  assign bus.rx_bit = q.rx_bit;
endmodule // cebt_bit_timer
`default_nettype wire

/* File: cebt_err_counters.sv */
// transmit and receive error counters and the error state they select
`timescale 1ns/10ps
`default_nettype none
`include "cebt_defines.svh"
module cebt_err_counters import cebt_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // counter updates and state
  cebt_if.cnt bus
);
  typedef struct packed {
    logic [8:0] tec;
    logic [7:0] rec;
    cebt_err_state_t state;
    logic warn;
  } cebt_cnt_st_t;
  cebt_cnt_st_t q, d;
  logic [9:0] tsum;
  logic [8:0] rsum;
  always_comb begin
    d = q;
    tsum = {1'b0, q.tec} + {5'h00, bus.tec_inc};
    rsum = {1'b0, q.rec} + {4'h0, bus.rec_inc};
    if (bus.clr) begin
      d.tec = 9'h000;
      d.rec = 8'h00;
    end else if (q.state != cebt_bus_off) begin
      // increments win over a decrement in the same cycle
      if (bus.tec_inc != 5'h00) begin
        d.tec = (tsum >= {1'b0, `CEBT_BUSOFF_LVL}) ? `CEBT_BUSOFF_LVL : tsum[8:0];
      end else if (bus.tec_dec && q.tec != 9'h000) begin
        d.tec = q.tec - 9'h001;
      end
      if (bus.rec_inc != 5'h00) begin
        d.rec = rsum[8] ? `CEBT_REC_MAX : rsum[7:0];
      end else if (bus.rec_dec) begin
        if (q.rec > `CEBT_REC_TOP_ACTIVE) begin
          d.rec = `CEBT_REC_RESTORE;
        end else if (q.rec != 8'h00) begin
          d.rec = q.rec - 8'h01;
        end
      end
    end
    if (d.tec >= `CEBT_BUSOFF_LVL) begin
      d.state = cebt_bus_off;
    end else if (d.tec >= `CEBT_PASSIVE_LVL || {1'b0, d.rec} >= `CEBT_PASSIVE_LVL) begin
      d.state = cebt_passive;
    end else begin
      d.state = cebt_active;
    end
    d.warn = (d.tec > `CEBT_WARN_LVL) || ({1'b0, d.rec} > `CEBT_WARN_LVL);
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{tec: 9'h000, rec: 8'h00, state: cebt_active, warn: 1'b0};
    end else begin
      q <= d;
    end
  end
  assign bus.tec = q.tec;
  assign bus.rec = q.rec;
  assign bus.state = q.state;
  assign bus.warn = q.warn;
endmodule // cebt_err_counters
`default_nettype wire

/* File: cebt_core.sv */
// can error confinement core: error and overload frames, counters, bit timing
//
// Overview of operation
// - after an error frame a transmitter resends its data or remote frame
// - single-shot option suppresses that automatic resend
// - node is error active, error passive or bus off from its counters
// - warning raised when either error counter is above 96
// - lone transmitter without acknowledge stops counting once above 127
// - bus off never drives dominant; reception carries on
// - error active (0 to 127) sends six dominant flag bits
// - passive when transmit 128-255 or receive 128+; six recessive flag bits
// - transmit counter above 255 gives bus off; receive counter never does
// - counters rise on first flag bit, fall after good frames
// - receiver error adds one, except bit errors inside own flags
// - receiver seeing dominant right after own flag adds eight
// - transmitter flag adds eight, except passive ack case and arbitration stuff
// - bit error in active or overload flag adds eight to own counter
// - fourteen dominants from flag start, then each eight, add eight to both
// - good transmission takes one from transmit counter, floor zero
// - good reception: minus one, stays zero, or drops to 119-127
// - dominant first intermission bit is overload; transmit waits for bus idle
// - bit lasts 8 to 25 quanta (setups of 5 to 7 still run, with cfg_err set); shortest quantum one system clock
// - sync quantum, then propagation and phase one of 1 to 8 quanta
// - jump width 1 to 4 quanta, never above phase two (a wider setting only sets cfg_err)
// - error frame starts on the bit after the one with the error
`timescale 1ns/10ps
`default_nettype none
`include "cebt_defines.svh"
module cebt_core import cebt_pkg::*; #(
  parameter int PRESC_W = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bit timing setup
  input wire logic [PRESC_W-1:0] presc,
  input wire logic [2:0] prop_seg,
  input wire logic [2:0] ph1_seg,
  input wire logic [1:0] sjw,
  input wire logic single_shot,
  // protocol engine status
  input wire logic is_tx,
  input wire logic in_arb,
  input wire logic bus_idle,
  input wire logic frame_end,
  input wire logic tx_ok,
  input wire logic rx_ok,
  input wire logic tx_req,
  input wire logic tx_bit,
  // protocol engine errors
  input wire logic err_bit,
  input wire logic err_stuff,
  input wire logic err_form,
  input wire logic err_ack,
  input wire logic err_crc,
  // transceiver
  input wire logic rx_pin,
  output logic tx_pin,
  // status
  output logic tx_grant,
  output logic retx,
  output logic shot_drop,
  output logic cfg_err,
  output logic [8:0] tec,
  output logic [7:0] rec,
  output cebt_err_state_t err_state,
  output logic warn,
  output logic sample_pt,
  output logic rx_bit
);
  if (PRESC_W < 1 || PRESC_W > 16) begin : g_chk
    $error("cebt_core: PRESC_W must be 1 to 16");
  end

  typedef struct packed {
    cebt_fsm_t st;
    logic [3:0] bcnt;
    logic [3:0] dom_left;
    logic err_pend;
    logic pend_tx;
    logic pend_ack;
    logic pend_arb;
    logic was_tx;
    logic act_flag;
    logic seen_dom;
    logic err_frame;
    logic defer;
    logic [3:0] rbits;
    logic [7:0] rseq;
    logic tx;
    logic grant;
    logic retx;
    logic shot_drop;
    logic cfg_err;
  } cebt_core_st_t;

  localparam cebt_core_st_t CORE_RST = '{st: st_frame, tx: 1'b1, default: '0};

  cebt_core_st_t q, d;
  logic [4:0] tinc;
  logic [4:0] rinc;
  logic [4:0] dstep;
  logic clr_c;
  logic busoff;
  logic active;

  // one dominant sample of the flag run: msb marks an eight-step
  function automatic logic [4:0] dom_step(input logic [3:0] left);
    if (left == 4'h0) begin
      return 5'h00;
    end
    if (left == 4'h1) begin
      return {1'b1, `CEBT_DOM_NEXT};
    end
    return {1'b0, left - 4'h1};
  endfunction

  cebt_if link();

  cebt_bit_timer #(
    .PRESC_W(PRESC_W)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .presc(presc),
    .prop_seg(prop_seg),
    .ph1_seg(ph1_seg),
    .rx_pin(rx_pin),
    .bus(link)
  );

  cebt_err_counters u_cnt (
    .clk(clk),
    .rst(rst),
    .bus(link)
  );

  always_comb begin
    d = q;
    tinc = 5'h00;
    rinc = 5'h00;
    dstep = 5'h00;
    clr_c = 1'b0;
    busoff = (link.state == cebt_bus_off);
    active = (link.state == cebt_active);
    d.retx = 1'b0;
    d.shot_drop = 1'b0;
    // setup sanity only flagged: the timer still runs on what it is given
    d.cfg_err = (cebt_bit_len(prop_seg, ph1_seg) < `CEBT_BIT_TQ_MIN) ||
      ({3'h0, sjw} + 5'h01 > cebt_ph2_len(ph1_seg));
    if (bus_idle) begin
      d.defer = 1'b0;
    end
    d.grant = tx_req && bus_idle && !q.defer && !busoff && !q.err_pend &&
      q.st == st_frame;
    // engine errors are caught during frames only
    if (q.st == st_frame && (err_bit || err_stuff || err_form || err_ack || err_crc)) begin
      d.err_pend = 1'b1;
      d.pend_tx = is_tx;
      d.pend_ack = err_ack;
      d.pend_arb = err_stuff && in_arb;
    end
    if (q.st == st_frame && frame_end && !q.err_pend) begin
      d.st = st_inter;
      d.bcnt = 4'h0;
    end
    if (link.bit_start) begin
      if (q.st == st_frame && q.err_pend) begin
        d.st = st_flag;
        d.bcnt = 4'h0;
        d.err_pend = 1'b0;
        d.was_tx = q.pend_tx;
        d.act_flag = active;
        d.seen_dom = 1'b0;
        d.err_frame = 1'b1;
        d.dom_left = active ? `CEBT_DOM_FIRST : 4'h0;
      end
      case (d.st)
        st_frame: begin
          d.tx = tx_bit;
        end
        st_flag: begin
          d.tx = !d.act_flag;
        end
        st_ovl: begin
          d.tx = 1'b0;
        end
        default: begin
          d.tx = 1'b1;
        end
      endcase
      if (busoff) begin
        d.tx = 1'b1;
      end
    end
    if (link.sample_pt) begin
      dstep = dom_step(q.dom_left);
      case (q.st)
        st_flag, st_ovl: begin
          if (q.st == st_flag && q.bcnt == 4'h0) begin
            if (!q.pend_tx) begin
              rinc = `CEBT_INC_RX;
            end else if (!q.pend_arb && !(q.pend_ack && !q.act_flag)) begin
              tinc = `CEBT_INC_ERR;
            end
          end
          if (q.act_flag && active && link.rx_bit) begin
            if (q.was_tx) begin
              tinc = tinc + `CEBT_INC_ERR;
            end else begin
              rinc = rinc + `CEBT_INC_ERR;
            end
            d.dom_left = `CEBT_DOM_FIRST;
          end else if (!link.rx_bit) begin
            d.seen_dom = 1'b1;
            d.dom_left = dstep[3:0];
            if (dstep[4]) begin
              tinc = tinc + `CEBT_INC_ERR;
              rinc = rinc + `CEBT_INC_ERR;
            end
          end
          if (q.bcnt == `CEBT_FLAG_BITS - 4'h1) begin
            // passive ack error counts only if someone answered with dominant
            if (q.st == st_flag && q.pend_tx && q.pend_ack && !q.act_flag &&
                d.seen_dom && link.tec < `CEBT_PASSIVE_LVL) begin
              tinc = tinc + `CEBT_INC_ERR;
            end
            d.st = st_trail;
            d.bcnt = 4'h0;
            if (!q.act_flag) begin
              d.dom_left = `CEBT_DOM_NEXT;
            end
          end else begin
            d.bcnt = q.bcnt + 4'h1;
          end
        end
        st_trail: begin
          if (!link.rx_bit) begin
            if (q.bcnt == 4'h0 && q.err_frame && !q.was_tx) begin
              rinc = rinc + `CEBT_INC_ERR;
            end
            d.bcnt = 4'h1;
            d.dom_left = dstep[3:0];
            if (dstep[4]) begin
              tinc = tinc + `CEBT_INC_ERR;
              rinc = rinc + `CEBT_INC_ERR;
            end
          end else begin
            // the first recessive sample is already delimiter bit one
            d.st = st_delim;
            d.bcnt = 4'h1;
          end
        end
        st_delim: begin
          if (!link.rx_bit) begin
            // dominant inside a delimiter is a form error: new flag next bit
            d.st = st_frame;
            d.err_pend = 1'b1;
            d.pend_tx = q.was_tx;
            d.pend_ack = 1'b0;
            d.pend_arb = 1'b0;
          end else if (q.bcnt == `CEBT_DELIM_BITS - 4'h1) begin
            d.st = st_inter;
            d.bcnt = 4'h0;
            d.err_frame = 1'b0;
            if (q.err_frame && q.was_tx) begin
              if (single_shot) begin
                d.shot_drop = 1'b1;
              end else if (!busoff) begin
                d.retx = 1'b1;
              end
            end
          end else begin
            d.bcnt = q.bcnt + 4'h1;
          end
        end
        st_inter: begin
          if (!link.rx_bit && q.bcnt == 4'h0) begin
            d.st = st_ovl;
            d.bcnt = 4'h0;
            d.act_flag = 1'b1;
            d.was_tx = 1'b0;
            d.defer = 1'b1;
            d.dom_left = `CEBT_DOM_FIRST;
          end else if (!link.rx_bit || q.bcnt == `CEBT_INTER_BITS - 4'h1) begin
            // later dominant is another node's start of frame
            d.st = st_frame;
            d.bcnt = 4'h0;
          end else begin
            d.bcnt = q.bcnt + 4'h1;
          end
        end
        default: begin
          d.bcnt = q.bcnt;
        end
      endcase
      // leave bus off after 128 runs of 11 recessive bits
      if (busoff) begin
        if (!link.rx_bit) begin
          d.rbits = 4'h0;
        end else if (q.rbits == `CEBT_RECOV_BITS - 4'h1) begin
          d.rbits = 4'h0;
          if (q.rseq == `CEBT_RECOV_SEQ - 8'h01) begin
            d.rseq = 8'h00;
            clr_c = 1'b1;
          end else begin
            d.rseq = q.rseq + 8'h01;
          end
        end else begin
          d.rbits = q.rbits + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  assign link.tec_inc = tinc;
  assign link.rec_inc = rinc;
  assign link.tec_dec = tx_ok;
  assign link.rec_dec = rx_ok;
  assign link.clr = clr_c;

  assign tx_pin = q.tx;
  assign tx_grant = q.grant;
  assign retx = q.retx;
  assign shot_drop = q.shot_drop;
  assign cfg_err = q.cfg_err;
  assign tec = link.tec;
  assign rec = link.rec;
  assign err_state = link.state;
  assign warn = link.warn;
  assign sample_pt = link.sample_pt;
  assign rx_bit = link.rx_bit;
endmodule // cebt_core
`default_nettype wire

/* File: cebt_core_assertions.sv */
// concurrent checks on the ports of the error confinement core
`timescale 1ns/10ps
`default_nettype none
module cebt_core_assertions import cebt_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // setup
  input wire logic [2:0] prop_seg,
  input wire logic [2:0] ph1_seg,
  input wire logic [1:0] sjw,
  input wire logic single_shot,
  // bus
  input wire logic rx_pin,
  input wire logic tx_pin,
  // status
  input wire logic retx,
  input wire logic shot_drop,
  input wire logic cfg_err,
  input wire logic [8:0] tec,
  input wire logic [7:0] rec,
  input wire cebt_err_state_t err_state,
  input wire logic warn,
  input wire logic sample_pt,
  input wire logic rx_bit
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [4:0] ph2;
  logic [4:0] blen;
  logic cfg_x;
  // own reckoning of the bit, kept apart from the package helpers
  assign ph2 = (ph1_seg == 3'h0) ? 5'h02 : {2'h0, ph1_seg} + 5'h01;
  assign blen = 5'h03 + {2'h0, prop_seg} + {2'h0, ph1_seg} + ph2;
  assign cfg_x = (blen < 5'h08) || ({3'h0, sjw} + 5'h01 > ph2);
  chk_cfg_check: assert property (!$past(rst) |-> cfg_err == $past(cfg_x))
    else $error("cfg_err does not follow the timing setup");
  chk_state_map: assert property (err_state == ((tec > 9'h0ff) ? cebt_bus_off :
    ((tec > 9'h07f || rec > 8'h7f) ? cebt_passive : cebt_active)))
    else $error("error state does not follow the counters");
  chk_warn_level: assert property (warn == (tec > 9'h060 || rec > 8'h60))
    else $error("warning flag does not follow the counters");
  chk_busoff_quiet: assert property ((err_state == cebt_bus_off) [*2] |-> tx_pin)
    else $error("dominant driven while bus off");
  chk_tec_steps: assert property (tec != $past(tec) |-> tec == $past(tec) + 9'h008 ||
    tec + 9'h001 == $past(tec) || tec == 9'h000 || tec == 9'h100)
    else $error("transmit counter moved by an illegal step");
  chk_rec_steps: assert property (rec != $past(rec) |-> rec == $past(rec) + 8'h01 ||
    rec == $past(rec) + 8'h08 || rec + 8'h01 == $past(rec) || rec == 8'hff ||
    rec == 8'h00 || ($past(rec) > 8'h7f && rec inside {[8'h77:8'h7f]}))
    else $error("receive counter moved by an illegal step");
  chk_tec_clamp: assert property (tec <= 9'h100)
    else $error("transmit counter above bus off level");
  chk_sample_once: assert property (sample_pt |=> !sample_pt [*4])
    else $error("two sample points inside one bit");
  chk_rx_capture: assert property (sample_pt |-> rx_bit == $past(rx_pin))
    else $error("sampled bit differs from the bus level");
  chk_resend_mode: assert property (retx |-> !shot_drop && !single_shot)
    else $error("resend given while single shot is set");
  cov_retx: cover property (retx);
  cov_drop: cover property (shot_drop);
  cov_bus_off: cover property (err_state == cebt_bus_off);
  cov_cfg_err: cover property (cfg_err);
endmodule // cebt_core_assertions
bind cebt_core cebt_core_assertions u_chk (.clk(clk), .rst(rst), .prop_seg(prop_seg),
  .ph1_seg(ph1_seg), .sjw(sjw), .single_shot(single_shot), .rx_pin(rx_pin), .tx_pin(tx_pin),
  .retx(retx), .shot_drop(shot_drop), .cfg_err(cfg_err), .tec(tec), .rec(rec),
  .err_state(err_state), .warn(warn), .sample_pt(sample_pt), .rx_bit(rx_bit));
`default_nettype wire

/* File: cebt_node_model.sv */
// other nodes on the bus behind the transceiver
`timescale 1ns/10ps
`default_nettype none
module cebt_node_model (
  // node side
  input wire logic tx_pin,
  input wire logic dom_req,
  // bus
  output logic rx_pin
);
  // wired-and: any dominant driver wins, idle bus is recessive
  assign rx_pin = tx_pin & ~dom_req;
endmodule // cebt_node_model
`default_nettype wire

/* File: cebt_core_test.sv */
// self-checking bench for the error confinement core
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module cebt_core_test import cebt_pkg::*; ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] presc = 6'h00;
  logic [2:0] prop_seg = 3'h2;
  logic [2:0] ph1_seg = 3'h2;
  logic [1:0] sjw = 2'h0;
  logic single_shot, is_tx, in_arb, bus_idle, frame_end, tx_ok, rx_ok, tx_req, tx_bit, dom;
  logic [4:0] errs;
  logic tx_pin, rx_pin, tx_grant, retx, shot_drop, cfg_err, warn, sample_pt, rx_bit;
  logic [8:0] tec;
  logic [7:0] rec;
  cebt_err_state_t err_state;
  logic [8:0] e_tec;
  logic [7:0] e_rec;
  logic [4:0] kinds [4] = '{5'h10, 5'h08, 5'h04, 5'h01};
  int err_total = 0, n_tests = 0, n_retx = 0, n_drop = 0, n;
  cebt_core i_dut (.clk(clk), .rst(rst), .presc(presc), .prop_seg(prop_seg), .ph1_seg(ph1_seg),
    .sjw(sjw), .single_shot(single_shot), .is_tx(is_tx), .in_arb(in_arb), .bus_idle(bus_idle),
    .frame_end(frame_end), .tx_ok(tx_ok), .rx_ok(rx_ok), .tx_req(tx_req), .tx_bit(tx_bit),
    .err_bit(errs[4]), .err_stuff(errs[3]), .err_form(errs[2]), .err_ack(errs[1]),
    .err_crc(errs[0]), .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_grant(tx_grant), .retx(retx),
    .shot_drop(shot_drop), .cfg_err(cfg_err), .tec(tec), .rec(rec), .err_state(err_state),
    .warn(warn), .sample_pt(sample_pt), .rx_bit(rx_bit));
  cebt_node_model i_bus (.tx_pin(tx_pin), .dom_req(dom), .rx_pin(rx_pin));
  always #4 clk = ~clk;
  always @(negedge clk) begin
    if (retx === 1'b1) n_retx++;
    if (shot_drop === 1'b1) n_drop++;
  end
  function automatic int ph2(input logic [2:0] p1);
    return (p1 == 3'h0) ? 2 : int'(p1) + 1;
  endfunction
  function automatic int blen(input logic [2:0] pr, input logic [2:0] p1);
    return 3 + int'(pr) + int'(p1) + ph2(p1);
  endfunction
  function automatic cebt_err_state_t f_st(input logic [8:0] t, input logic [7:0] r);
    if (t > 9'h0ff) return cebt_bus_off;
    if (t > 9'h07f || r > 8'h7f) return cebt_passive;
    return cebt_active;
  endfunction
  // lone passive sender without ack, or stuff error in arbitration, keeps its count
  function automatic logic [8:0] f_tec(input logic [8:0] t, input logic [4:0] k);
    if ((k == 5'h02 && t > 9'h07f) || (k == 5'h08 && in_arb)) return t;
    return (t > 9'h0f8) ? 9'h100 : t + 9'h008;
  endfunction
  function automatic logic [7:0] f_rec(input logic [7:0] r, input logic d);
    logic [8:0] s;
    s = {1'b0, r} + (d ? 9'h009 : 9'h001);
    return (s > 9'h0ff) ? 8'hff : s[7:0];
  endfunction
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s ends, mismatches %0d", s, err_total);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // wait for k sample points, return just after the following edge
  task automatic sp(input int k);
    repeat (k) begin
      @(negedge clk);
      while (sample_pt !== 1'b1) @(negedge clk);
    end
    cyc(1);
  endtask
  task automatic rt;
    rst = 1'b1;
    cyc(5);
    `CHK("reset", {2'b11, cebt_active, 17'h0}, {tx_pin, rx_bit, err_state, tec, rec});
    rst = 1'b0;
    e_tec = 9'h000;
    e_rec = 8'h00;
  endtask
  task automatic okp(input logic t);
    tx_ok = t;
    rx_ok = ~t;
    cyc(1);
    tx_ok = 1'b0;
    rx_ok = 1'b0;
    cyc(1);
  endtask
  task automatic flag6(input logic act);
    logic [5:0] fl;
    for (int i = 0; i < 6; i++) begin
      sp(1);
      fl[i] = tx_pin;
      if (i == 0 && is_tx) begin
        cyc(1);
        `CHK("tec_first", e_tec, tec);
      end
    end
    `CHK("flag", act ? 6'h00 : 6'h3f, fl);
  endtask
  // error taken in the bit where it is seen; d adds one dominant bit after the flag
  task automatic errf(input logic [4:0] k, input logic tx, input logic d);
    logic act;
    act = (err_state === cebt_active);
    is_tx = tx;
    if (tx) e_tec = f_tec(e_tec, k);
    else e_rec = f_rec(e_rec, d);
    sp(1);
    errs = k;
    cyc(1);
    errs = 5'h00;
    flag6(act);
    if (d) begin
      dom = 1'b1;
      sp(1);
      dom = 1'b0;
    end
    sp(12);
  endtask
  initial begin
    #480000;
    err_total++;
    conclude;
  end
  initial begin
    void'($urandom(32'hf487));
    {single_shot, is_tx, in_arb, bus_idle, frame_end, tx_ok, rx_ok, tx_req, dom} = 9'h000;
    tx_bit = 1'b1;
    errs = 5'h00;
    rt;
    // shortest and longest bit first, then random setups
    for (int i = 0; i < 6; i++) begin
      // timer held in reset while the setup changes, so no bit is cut short
      rst = 1'b1;
      presc = (i == 0) ? 6'h00 : 6'($urandom % 4);
      prop_seg = (i < 2) ? {3{i[0]}} : 3'($urandom);
      ph1_seg = (i < 2) ? {3{i[0]}} : 3'($urandom);
      sjw = (i == 0) ? 2'h3 : 2'($urandom);
      tx_bit = 1'($urandom);
      cyc(1);
      rst = 1'b0;
      sp(2);
      dom = 1'($urandom);
      sp(1);
      `CHK("rx_bit", tx_bit & ~dom, rx_bit);
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (sample_pt !== 1'b1);
      `CHK("period", (int'(presc) + 1) * blen(prop_seg, ph1_seg), n);
      `CHK("cfg_err", blen(prop_seg, ph1_seg) < 8 || sjw + 1 > ph2(ph1_seg), cfg_err);
      cyc(1);
    end
    {presc, prop_seg, ph1_seg, sjw, tx_bit, dom} = {6'h00, 3'h2, 3'h2, 2'h0, 2'b10};
    rt;
    done("timing");
    for (int i = 0; i < 20; i++) begin
      errf(5'h02, 1'b1, 1'b0);
      `CHK("tec", e_tec, tec);
      `CHK("state", f_st(e_tec, e_rec), err_state);
      `CHK("warn", e_tec > 9'h060, warn);
    end
    `CHK("retx", 20, n_retx);
    in_arb = 1'b1;
    errf(5'h08, 1'b1, 1'b0);
    in_arb = 1'b0;
    single_shot = 1'b1;
    errf(5'h02, 1'b1, 1'b0);
    single_shot = 1'b0;
    `CHK("drop", 1, n_drop);
    `CHK("retx2", 21, n_retx);
    done("transmit errors");
    n = 1 + $urandom % 5;
    repeat (n) begin
      okp(1'b1);
      e_tec = e_tec - 9'h001;
      `CHK("tec_dec", e_tec, tec);
    end
    `CHK("state2", cebt_active, err_state);
    rt;
    okp(1'b1);
    okp(1'b0);
    `CHK("floor", 17'h0, {tec, rec});
    for (int i = 0; i < 40 && e_rec < 8'h80; i++) begin
      errf(kinds[$urandom % 4], 1'b0, 1'($urandom % 4 != 0));
      `CHK("rec", e_rec, rec);
    end
    okp(1'b0);
    `CHK("restore", {cebt_active, 8'h7f}, {err_state, rec});
    okp(1'b0);
    `CHK("rec_dec", 8'h7e, rec);
    done("receive errors");
    rt;
    repeat (32) errf(5'h10, 1'b1, 1'b0);
    `CHK("bus_off", {cebt_bus_off, 9'h100}, {err_state, tec});
    sp(1380);
    `CHK("still_off", cebt_bus_off, err_state);
    sp(30);
    `CHK("recover", {cebt_active, 9'h000}, {err_state, tec});
    done("bus off");
    rt;
    is_tx = 1'b0;
    tx_req = 1'b1;
    sp(1);
    frame_end = 1'b1;
    cyc(1);
    frame_end = 1'b0;
    dom = 1'b1;
    sp(1);
    dom = 1'b0;
    flag6(1'b1);
    `CHK("defer", 1'b0, tx_grant);
    // eight more dominant bits make fourteen from the flag start
    dom = 1'b1;
    sp(8);
    dom = 1'b0;
    `CHK("dom_run", {9'h008, 8'h08}, {tec, rec});
    sp(12);
    bus_idle = 1'b1;
    cyc(1);
    `CHK("defer_idle", 1'b0, tx_grant);
    cyc(2);
    `CHK("grant", 1'b1, tx_grant);
    done("overload");
    conclude;
  end
endmodule // cebt_core_test
`default_nettype wire
